// ===== design/dac_map.vh
`ifndef DAC_MAP_VH
`define DAC_MAP_VH

`define DAC_WORD_W 14
`define DAC_LEVEL_W 16
`define DAC_LATENCY 6

`define DAC_CODE_MAX 16'sh1FFF
`define DAC_CODE_MIN (-16'sh2000)
`define DAC_CODE_MID 16'h2000

`define DAC_FMT_BIN_OFF 2'h0
`define DAC_FMT_BIN_ON 2'h1
`define DAC_FMT_TWO_ON 2'h2
`define DAC_FMT_TWO_OFF 2'h3

`define DAC_PWR_NORMAL 2'h0
`define DAC_PWR_HIZ 2'h1
`define DAC_PWR_NAP 2'h2
`define DAC_PWR_SLEEP 2'h3

`define DAC_ADDR_W 4
`define DAC_OFF_CONFIG 4'h0
`define DAC_OFF_STATUS 4'h4
`define DAC_OFF_MASK 4'h8
`define DAC_OFF_STATE 4'hC

`define DAC_CONFIG_RESET 2'h3
`define DAC_RESP_OKAY 2'h0
`define DAC_RESP_SLVERR 2'h2

`endif

// ===== design/dac_output_control.v
`timescale 1ns/100ps
`include "dac_map.vh"

module dac_output_control #(
    parameter LATENCY = `DAC_LATENCY
) (
    input wire aclk,
    input wire aresetn,
    input wire [`DAC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`DAC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire bus_swap_select,
    input wire chan_a_power_select,
    input wire chan_b_power_select,
    input wire chan_a_output_enable_n,
    input wire chan_b_output_enable_n,
    input wire [1:0] format_select,
    input wire chan_a_sample_clock,
    input wire chan_b_sample_clock,
    input wire signed [`DAC_LEVEL_W-1:0] chan_a_level,
    input wire signed [`DAC_LEVEL_W-1:0] chan_b_level,
    output reg [`DAC_WORD_W-1:0] bus_a_word,
    output reg bus_a_range_flag,
    output reg bus_a_oe,
    output reg [`DAC_WORD_W-1:0] bus_b_word,
    output reg bus_b_range_flag,
    output reg bus_b_oe,
    output reg stabilizer_on,
    output wire irq
);

    localparam SYNC_W = 9 + 2 * `DAC_LEVEL_W;
    localparam CW = `DAC_WORD_W + 1;

    // Quantise a level to {range flag, straight binary code}
    function [CW-1:0] dac_quantise;
        input signed [`DAC_LEVEL_W-1:0] lvl;
        reg [`DAC_LEVEL_W-1:0] sum;
        begin
            sum = lvl + `DAC_CODE_MID;
            if (lvl > `DAC_CODE_MAX) begin
                dac_quantise = {1'b1, {`DAC_WORD_W{1'b1}}};
            end else if (lvl < `DAC_CODE_MIN) begin
                dac_quantise = {1'b1, {`DAC_WORD_W{1'b0}}};
            end else begin
                dac_quantise = {1'b0, sum[`DAC_WORD_W-1:0]};
            end
        end
    endfunction

    // Power and output state from the two channel pins
    function [1:0] dac_power_mode;
        input pwr;
        input oe_n;
        begin
            dac_power_mode = {pwr, oe_n};
        end
    endfunction

    // Two sync stages for every pin input
    reg [SYNC_W-1:0] sync1_reg;
    reg [SYNC_W-1:0] sync2_reg;
    wire [SYNC_W-1:0] pins = {bus_swap_select, chan_a_power_select, chan_b_power_select,
        chan_a_output_enable_n, chan_b_output_enable_n, format_select,
        chan_a_sample_clock, chan_b_sample_clock, chan_a_level, chan_b_level};

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= {SYNC_W{1'b0}};
            sync2_reg <= {SYNC_W{1'b0}};
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    wire swap_s = sync2_reg[SYNC_W-1];
    wire pwr_a_s = sync2_reg[SYNC_W-2];
    wire pwr_b_s = sync2_reg[SYNC_W-3];
    wire oen_a_s = sync2_reg[SYNC_W-4];
    wire oen_b_s = sync2_reg[SYNC_W-5];
    wire [1:0] fmt_s = sync2_reg[SYNC_W-6:SYNC_W-7];
    wire clk_a_s = sync2_reg[SYNC_W-8];
    wire clk_b_s = sync2_reg[SYNC_W-9];
    wire [`DAC_LEVEL_W-1:0] lvl_a_s = sync2_reg[2*`DAC_LEVEL_W-1:`DAC_LEVEL_W];
    wire [`DAC_LEVEL_W-1:0] lvl_b_s = sync2_reg[`DAC_LEVEL_W-1:0];

    wire [1:0] mode_a = dac_power_mode(pwr_a_s, oen_a_s);
    wire [1:0] mode_b = dac_power_mode(pwr_b_s, oen_b_s);
    wire run_a = !pwr_a_s;
    wire run_b = !pwr_b_s;
    wire drive_a = (mode_a == `DAC_PWR_NORMAL);
    wire drive_b = (mode_b == `DAC_PWR_NORMAL);
    wire twos = fmt_s[1];

    reg [1:0] config_reg;
    reg [1:0] status_reg;
    reg [1:0] mask_reg;

    reg clk_a_prev_reg;
    reg clk_b_prev_reg;
    reg [`DAC_LEVEL_W-1:0] hold_a_reg;
    reg [`DAC_LEVEL_W-1:0] hold_b_reg;
    // A capture needs a synced rising edge on a running, enabled channel,
    // so nap and sleep freeze the whole pipeline until the channel wakes
    wire rise_a = clk_a_s && !clk_a_prev_reg && run_a && config_reg[0];
    wire rise_b = clk_b_s && !clk_b_prev_reg && run_b && config_reg[1];

    // Stage pipelines, index 0 is the newest sample
    reg [CW-1:0] pipe_a [0:LATENCY-1];
    reg [CW-1:0] pipe_b [0:LATENCY-1];
    reg [CW-1:0] out_a_reg;
    reg [CW-1:0] out_b_reg;
    integer i;

    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_a_prev_reg <= 1'b0;
            clk_b_prev_reg <= 1'b0;
            hold_a_reg <= {`DAC_LEVEL_W{1'b0}};
            hold_b_reg <= {`DAC_LEVEL_W{1'b0}};
            out_a_reg <= {CW{1'b0}};
            out_b_reg <= {CW{1'b0}};
            for (i = 0; i < LATENCY; i = i + 1) begin
                pipe_a[i] <= {CW{1'b0}};
                pipe_b[i] <= {CW{1'b0}};
            end
        end else begin
            clk_a_prev_reg <= clk_a_s;
            clk_b_prev_reg <= clk_b_s;
            // Track while low, freeze while high
            if (!clk_a_s) begin
                hold_a_reg <= lvl_a_s;
            end
            if (!clk_b_s) begin
                hold_b_reg <= lvl_b_s;
            end
            if (rise_a) begin
                pipe_a[0] <= dac_quantise(hold_a_reg);
                for (i = 1; i < LATENCY; i = i + 1) begin
                    pipe_a[i] <= pipe_a[i-1];
                end
                out_a_reg <= pipe_a[LATENCY-1];
            end
            if (rise_b) begin
                pipe_b[0] <= dac_quantise(hold_b_reg);
                for (i = 1; i < LATENCY; i = i + 1) begin
                    pipe_b[i] <= pipe_b[i-1];
                end
                out_b_reg <= pipe_b[LATENCY-1];
            end
        end
    end

    // Output coding, top bit inverted for twos complement
    wire [`DAC_WORD_W-1:0] word_a = out_a_reg[`DAC_WORD_W-1:0] ^ {twos, {(`DAC_WORD_W-1){1'b0}}};
    wire [`DAC_WORD_W-1:0] word_b = out_b_reg[`DAC_WORD_W-1:0] ^ {twos, {(`DAC_WORD_W-1){1'b0}}};
    wire flag_a = out_a_reg[CW-1];
    wire flag_b = out_b_reg[CW-1];

    always @(posedge aclk) begin
        if (!aresetn) begin
            bus_a_word <= {`DAC_WORD_W{1'b0}};
            bus_b_word <= {`DAC_WORD_W{1'b0}};
            bus_a_range_flag <= 1'b0;
            bus_b_range_flag <= 1'b0;
            bus_a_oe <= 1'b0;
            bus_b_oe <= 1'b0;
            stabilizer_on <= 1'b0;
        end else begin
            stabilizer_on <= (fmt_s == `DAC_FMT_BIN_ON) || (fmt_s == `DAC_FMT_TWO_ON);
            if (swap_s) begin
                bus_a_word <= word_a;
                bus_a_range_flag <= flag_a;
                bus_a_oe <= drive_a;
                bus_b_word <= word_b;
                bus_b_range_flag <= flag_b;
                bus_b_oe <= drive_b;
            end else begin
                bus_a_word <= word_b;
                bus_a_range_flag <= flag_b;
                bus_a_oe <= drive_b;
                bus_b_word <= word_a;
                bus_b_range_flag <= flag_a;
                bus_b_oe <= drive_a;
            end
        end
    end

    // Range events: a new out-of-range word loaded into a channel buffer
    reg rise_a_d_reg;
    reg rise_b_d_reg;
    wire [1:0] events = {rise_b_d_reg && flag_b, rise_a_d_reg && flag_a};

    // AXI4-Lite slave
    reg aw_have_reg;
    reg w_have_reg;
    reg [`DAC_ADDR_W-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire wr_status = do_write && aw_addr_reg == `DAC_OFF_STATUS && w_strb_reg[0];
    wire [1:0] w1c = wr_status ? w_data_reg[1:0] : 2'h0;
    wire [1:0] status_next = (status_reg & ~w1c) | events;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rise_a_d_reg <= 1'b0;
            rise_b_d_reg <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= {`DAC_ADDR_W{1'b0}};
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DAC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DAC_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            config_reg <= `DAC_CONFIG_RESET;
            status_reg <= 2'h0;
            mask_reg <= 2'h0;
        end else begin
            rise_a_d_reg <= rise_a;
            rise_b_d_reg <= rise_b;
            status_reg <= status_next;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `DAC_RESP_OKAY;
                case (aw_addr_reg)
                    `DAC_OFF_CONFIG: begin
                        if (w_strb_reg[0]) begin
                            config_reg <= w_data_reg[1:0];
                        end
                    end
                    `DAC_OFF_MASK: begin
                        if (w_strb_reg[0]) begin
                            mask_reg <= w_data_reg[1:0];
                        end
                    end
                    `DAC_OFF_STATUS: begin
                    end
                    `DAC_OFF_STATE: begin
                    end
                    default: begin
                        s_axi_bresp <= `DAC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `DAC_RESP_OKAY;
                case (s_axi_araddr)
                    `DAC_OFF_CONFIG: s_axi_rdata <= {30'h0, config_reg};
                    `DAC_OFF_STATUS: s_axi_rdata <= {30'h0, status_reg};
                    `DAC_OFF_MASK: s_axi_rdata <= {30'h0, mask_reg};
                    `DAC_OFF_STATE: s_axi_rdata <= {23'h0, stabilizer_on, twos, fmt_s, swap_s, mode_b, mode_a};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `DAC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Level interrupt while any unmasked sticky event is pending
    assign irq = |(status_reg & mask_reg);

endmodule // dac_output_control

// ===== verif/dac_output_control_properties.sv
`timescale 1ns/100ps
`include "dac_map.vh"
module dac_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire bus_swap_select,
    input wire chan_a_power_select,
    input wire chan_a_output_enable_n,
    input wire [1:0] format_select,
    input wire [`DAC_WORD_W-1:0] bus_a_word,
    input wire bus_a_range_flag,
    input wire bus_a_oe,
    input wire stabilizer_on
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire chan_a_live = !chan_a_power_select && !chan_a_output_enable_n;
    a_oe_driven: assert property ((bus_swap_select && chan_a_live) [*5] |-> bus_a_oe)
        else $error("bus A not driven in normal mode");
    a_oe_released: assert property ((bus_swap_select && !chan_a_live) [*5] |-> !bus_a_oe)
        else $error("bus A driven while released");
    a_stab_on: assert property ((format_select == 2'h1 || format_select == 2'h2) [*5] |-> stabilizer_on)
        else $error("stabilizer off for middle levels");
    a_stab_off: assert property ((format_select == 2'h0 || format_select == 2'h3) [*5] |-> !stabilizer_on)
        else $error("stabilizer on for end levels");
    a_flag_code: assert property (bus_a_range_flag |-> bus_a_word inside {14'h3FFF, 14'h0, 14'h1FFF, 14'h2000})
        else $error("range flag with in-range word");
    a_flag_word_pair: assert property ($rose(bus_a_range_flag) |-> $changed(bus_a_word) ||
        ($past(bus_a_word) inside {14'h3FFF, 14'h0, 14'h1FFF, 14'h2000}))
        else $error("flag rose without word update");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during response");
    c_overflow: cover property (bus_a_range_flag && bus_a_oe);
    c_twos: cover property (format_select == 2'h3 && bus_a_oe);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // dac_checker

bind dac_output_control dac_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus_swap_select(bus_swap_select),
    .chan_a_power_select(chan_a_power_select), .chan_a_output_enable_n(chan_a_output_enable_n),
    .format_select(format_select), .bus_a_word(bus_a_word), .bus_a_range_flag(bus_a_range_flag),
    .bus_a_oe(bus_a_oe), .stabilizer_on(stabilizer_on));

// ===== verif/dac_bus_receiver.sv
`timescale 1ns/100ps
`include "dac_map.vh"
module dac_bus_receiver (
    input wire aclk,
    input wire [`DAC_WORD_W-1:0] pin_word,
    input wire pin_flag,
    input wire pin_oe,
    output reg [`DAC_WORD_W-1:0] got_word,
    output reg got_flag
);
    // A released bus floats, so the captured value keeps changing
    always @(posedge aclk) begin
        if (pin_oe) begin
            got_word <= pin_word;
            got_flag <= pin_flag;
        end else begin
            got_word <= ~got_word;
            got_flag <= ~got_flag;
        end
    end
endmodule // dac_bus_receiver

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic swap = 1, pwr_a = 0, pwr_b = 0, oen_a = 0, oen_b = 0, clk_a = 0, clk_b = 0;
    logic [1:0] fmt = 0;
    logic [15:0] lvl_a = 0, lvl_b = 0;
    wire awready, wready, bvalid, arready, rvalid, irq, a_oe, b_oe, a_flag, b_flag, stab, rx_flag;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [13:0] a_word, b_word, rx_word;
    integer err_count = 0, compares = 0, la = 0, lb = 0, f;
    always #50 aclk = ~aclk;
    dac_output_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_swap_select(swap),
        .chan_a_power_select(pwr_a), .chan_b_power_select(pwr_b), .chan_a_output_enable_n(oen_a),
        .chan_b_output_enable_n(oen_b), .format_select(fmt), .chan_a_sample_clock(clk_a),
        .chan_b_sample_clock(clk_b), .chan_a_level(lvl_a), .chan_b_level(lvl_b), .bus_a_word(a_word),
        .bus_a_range_flag(a_flag), .bus_a_oe(a_oe), .bus_b_word(b_word), .bus_b_range_flag(b_flag),
        .bus_b_oe(b_oe), .stabilizer_on(stab), .irq(irq));
    dac_bus_receiver rx_a (.aclk(aclk), .pin_word(a_word), .pin_flag(a_flag), .pin_oe(a_oe),
        .got_word(rx_word), .got_flag(rx_flag));
    task test_done;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic [13:0] ex(input integer l, input logic tw);
        integer c;
        c = l > 8191 ? 8191 : (l < -8192 ? -8192 : l);
        ex = 14'(c + 8192) ^ {tw, 13'h0};
    endfunction
    task wr(input logic [3:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        chk({awready, wready}, 2'h3);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk); n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1 && n < 50);
        chk(bvalid, 1);
        chk(bresp, (a[1:0] == 2'h0) ? 2'h0 : 2'h2);
        bready <= 0;
        @(posedge aclk);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] exp);
        integer n;
        n = 0;
        chk(arready, 1);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk); n++;
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1 && n < 50);
        chk(rvalid, 1);
        chk(rresp, (a[1:0] == 2'h0) ? 2'h0 : 2'h2);
        rready <= 0;
        chk(rdata, exp);
        @(posedge aclk);
    endtask
    // Sample clock periods: 3 aclk low, 5 aclk high; levels flip at each rise, a held sample ignores that
    task pulse(input integer n);
        repeat (n) begin
            clk_a <= 0; clk_b <= 0; lvl_a <= la[15:0]; lvl_b <= lb[15:0];
            repeat (3) @(posedge aclk);
            clk_a <= 1; clk_b <= 1; lvl_a <= ~la[15:0]; lvl_b <= ~lb[15:0];
            repeat (5) @(posedge aclk);
        end
    endtask
    task t_latency;
        la = 291; lb = -1110; pulse(8);
        chk(rx_word, ex(la, 0));
        chk(b_word, ex(lb, 0));
        la = 2748; pulse(6);
        chk(rx_word, ex(291, 0));
        pulse(1);
        @(posedge aclk);
        chk(rx_word, ex(la, 0));
    endtask
    task t_format;
        for (f = 0; f < 4; f++) begin
            fmt <= f[1:0]; pulse(1);
            chk(a_word, ex(la, f[1]));
            chk(b_word, ex(lb, f[1]));
            chk(stab, f == 1 || f == 2);
            rdc(4'hC, {23'h0, f == 1 || f == 2, f[1], f[1:0], 5'h10});
        end
        fmt <= 0;
    endtask
    task t_swap;
        swap <= 0; pulse(1);
        chk(a_word, ex(lb, 0));
        chk(b_word, ex(la, 0));
        swap <= 1; pulse(1);
        chk(a_word, ex(la, 0));
        chk(b_word, ex(lb, 0));
    endtask
    task t_mux;
        clk_a <= 0; clk_b <= 0; swap <= 0; lvl_a <= la[15:0]; lvl_b <= lb[15:0];
        repeat (4) @(posedge aclk);
        chk(a_word, ex(lb, 0));
        chk(b_word, ex(la, 0));
        clk_a <= 1; clk_b <= 1; swap <= 1;
        repeat (4) @(posedge aclk);
        chk(a_word, ex(la, 0));
    endtask
    task t_range;
        la = 9000; lb = -9000; pulse(7);
        @(posedge aclk);
        chk({rx_flag, rx_word}, {1'b1, 14'h3FFF});
        chk({b_flag, b_word}, {1'b1, 14'h0});
        rdc(4'h4, 32'h3);
        chk(irq, 0);
        wr(4'h8, 32'h1);
        chk(irq, 1);
        la = 100; lb = -100; pulse(7);
        chk({a_flag, b_flag}, 0);
        wr(4'h4, 32'h3);
        rdc(4'h4, 32'h0);
        chk(irq, 0);
        wr(4'h8, 32'h0);
    endtask
    task t_power;
        for (f = 0; f < 4; f++) begin
            {pwr_a, oen_a} <= f[1:0];
            {pwr_b, oen_b} <= 2'(3 - f);
            repeat (6) @(posedge aclk);
            chk(a_oe, f == 0);
            chk(b_oe, f == 3);
            rdc(4'hC, {28'h1, 2'(3 - f), f[1:0]});
        end
        // Nap must freeze the pipeline: stale samples come out after wake-up
        pwr_a <= 1; oen_a <= 0; la = 500; pulse(7);
        pwr_a <= 0; repeat (6) @(posedge aclk);
        pulse(1);
        chk(a_word, ex(100, 0));
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        rdc(4'h0, 32'h3);
        rdc(4'h4, 32'h0);
        rdc(4'h8, 32'h0);
        wr(4'h2, 32'h0);
        rdc(4'h6, 32'h0);
        rdc(4'h0, 32'h3);
        t_latency;
        t_format;
        t_swap;
        t_mux;
        t_range;
        t_power;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        test_done;
    end
endmodule // tb_top
